//--- hdl/dcsd_pkg.sv
// Constants, types and command table for the disk command issuer.
// Assumes a taskfile of eight byte registers reached at three address pins.
package dcsd_pkg;

  // ----------------------------------------------------------------
  // Taskfile addresses (read side in brackets)
  // ----------------------------------------------------------------
  localparam logic [2:0] TF_DATA = 3'h0; // Data port
  localparam logic [2:0] TF_FEAT = 3'h1; // Feature (error flags)
  localparam logic [2:0] TF_SCNT = 3'h2; // Sector count
  localparam logic [2:0] TF_DEVH = 3'h6; // Device/head
  localparam logic [2:0] TF_CMD = 3'h7; // Command (device status)

  // Device/head fixed bits and status/error bit positions
  localparam logic [7:0] DEVH_BASE = 8'ha0; // Bits 7 and 5 set, device bit clear
  localparam int DEVH_LBA = 6; // Addressing mode bit
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABT = 2;

  // Command codes
  localparam logic [7:0] CMD_IDENT = 8'hec;
  localparam logic [7:0] CMD_MON = 8'hb0;
  localparam logic [7:0] CMD_CFG = 8'hef;
  localparam logic [7:0] CMD_SETMAX = 8'hf9;

  // Operation numbers: 0 report, 1..11 monitoring, 12..26 configuration, 27 set max
  localparam int N_OPS = 28;
  localparam logic [4:0] OP_MON_LO = 5'h01;
  localparam logic [4:0] OP_CFG_LO = 5'h0c;
  localparam logic [4:0] OP_SETMAX = 5'h1b;
  localparam logic [7:0] OP_FEAT [N_OPS] = '{
    8'h00, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5, 8'hd6, 8'hd8, 8'hd9,
    8'hda, 8'hdb, 8'h05, 8'h85, 8'h66, 8'hcc, 8'h06, 8'h86, 8'h07, 8'h09,
    8'h89, 8'h42, 8'hc2, 8'h44, 8'hbb, 8'h55, 8'haa, 8'h00};
  // Operations that bring data in by programmed input
  localparam logic [N_OPS-1:0] OP_PIO_IN = 28'h0000047;

  // One sector of 16-bit words
  localparam int SECT_WORDS = 256;

  // ----------------------------------------------------------------
  // Software register map and interrupt bits
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_TF = 8'h08;
  localparam logic [7:0] REG_DATA = 8'h0c;
  localparam logic [7:0] REG_ISTAT = 8'h10;
  localparam logic [7:0] REG_IMASK = 8'h14;
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_BADOP = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  // Decoded command
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] feat;
    logic pio_in;
    logic valid;
  } dcsd_cmd_s;

  // Operation number to command, feature and protocol
  function automatic dcsd_cmd_s op_decode(input logic [4:0] op);
    dcsd_cmd_s r;
    r = '0;
    r.valid = (op < 5'(N_OPS));
    if (r.valid) begin
      r.feat = OP_FEAT[op];
      r.pio_in = OP_PIO_IN[op];
      if (op == OP_SETMAX) r.cmd = CMD_SETMAX;
      else if (op >= OP_CFG_LO) r.cmd = CMD_CFG;
      else if (op >= OP_MON_LO) r.cmd = CMD_MON;
      else r.cmd = CMD_IDENT;
    end
    return r;
  endfunction

endpackage

//--- hdl/dcsd_host.sv
// Host-side issuer of subcoded disk commands over a taskfile port.
// Assumes a registered taskfile: read data valid the cycle after tf_rd_o,
// and a Wishbone classic master holding its request until ack.
`timescale 1ns/10ps
module dcsd_host
  import dcsd_pkg::*;
#(
  parameter int WORDS = SECT_WORDS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq_o,
  output logic [2:0] tf_addr_o,
  output logic [15:0] tf_data_o,
  output logic tf_data_oe_o,
  input wire logic [15:0] tf_data_i,
  output logic tf_wr_o,
  output logic tf_rd_o,
  input wire logic tf_intrq_i
);

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    S_IDLE = 12'h001,
    S_FEAT = 12'h002,
    S_SCNT = 12'h004,
    S_DEVH = 12'h008,
    S_CMD = 12'h010,
    S_WAIT = 12'h020,
    S_RSTAT = 12'h040,
    S_RERR = 12'h080,
    S_CAP = 12'h100,
    S_XFER = 12'h200,
    S_DRD = 12'h400,
    S_DCAP = 12'h800
  } dcsd_state_e;

  dcsd_state_e state_q, state_d;
  dcsd_cmd_s dec_q; // Command in flight
  logic [7:0] scnt_q; // Sector count argument
  logic lba_q; // Addressing mode for this command
  logic opt_q; // Option bit for set maximum address
  logic [7:0] status_q; // Device status at completion
  logic [7:0] error_q; // Error flags at completion
  logic [8:0] cnt_q; // Words read in this sector
  logic [IRQ_W-1:0] istat_q, imask_q;
  logic ack_q;
  logic [31:0] dat_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // A request is taken once; the registered ack masks it in the answer
  // cycle, so a master holding stb until it sees ack is served once.
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire in_xfer = (state_q == S_XFER) | (state_q == S_DRD) | (state_q == S_DCAP);
  // Data port reads during a transfer wait for the device word
  wire data_rd = rd & (wb_adr_i == REG_DATA) & in_xfer;
  wire ctrl_wr = wr & (wb_adr_i == REG_CTRL) & wb_sel_i[0];
  wire dcsd_cmd_s new_dec = op_decode(wb_dat_i[4:0]);
  // A start while busy is dropped; the status register shows busy
  wire go = ctrl_wr & wb_dat_i[7] & (state_q == S_IDLE);
  wire start_ok = go & new_dec.valid;
  wire bad_op = go & ~new_dec.valid;
  wire last_word = (cnt_q == 9'(WORDS - 1));

  // Status is captured one cycle before the error byte lands, so the
  // data phase decision is ready while the error flags are on the bus.
  // Completion decisions taken while the error flags arrive
  wire dev_err = status_q[ST_ERR];
  wire pio_go = dec_q.pio_in & status_q[ST_DRQ] & ~dev_err;
  wire fin_cap = (state_q == S_CAP) & ~pio_go;
  wire fin_xfer = (state_q == S_DCAP) & last_word;

  // Events: an abort is an error status carrying the abort flag
  wire [IRQ_W-1:0] ev;
  assign ev[IRQ_DONE] = fin_cap | fin_xfer;
  assign ev[IRQ_ABORT] = fin_cap & dev_err & tf_data_i[ER_ABT];
  assign ev[IRQ_BADOP] = bad_op;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Feature, count, device/head and command go out on four back-to-back
  // cycles; then wait for the device interrupt, fetch status and error,
  // and either finish or serve data reads one word at a time.
  // There is no timeout on the wait: a device that never interrupts
  // keeps the issuer busy until rst_i is asserted.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: if (start_ok) state_d = S_FEAT;
      S_FEAT: state_d = S_SCNT;
      S_SCNT: state_d = S_DEVH;
      S_DEVH: state_d = S_CMD;
      S_CMD: state_d = S_WAIT;
      // Device raises its interrupt when the command is processed
      S_WAIT: if (tf_intrq_i) state_d = S_RSTAT;
      S_RSTAT: state_d = S_RERR;
      S_RERR: state_d = S_CAP;
      S_CAP: state_d = pio_go ? S_XFER : S_IDLE;
      S_XFER: if (data_rd) state_d = S_DRD;
      S_DRD: state_d = S_DCAP;
      S_DCAP: state_d = last_word ? S_IDLE : S_XFER;
      default: state_d = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) state_q <= S_IDLE;
    else state_q <= state_d;
  end

  // Latch the command on start; it stays stable through the sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_q <= '0;
      scnt_q <= 8'h00;
      lba_q <= 1'b0;
      opt_q <= 1'b0;
    end else if (start_ok) begin
      dec_q <= new_dec;
      scnt_q <= wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00;
      lba_q <= wb_dat_i[5];
      opt_q <= wb_dat_i[6];
    end
  end

  // ----------------------------------------------------------------
  // Taskfile drive
  // ----------------------------------------------------------------
  wire wr_phase = (state_q == S_FEAT) | (state_q == S_SCNT) |
                  (state_q == S_DEVH) | (state_q == S_CMD);
  // Set maximum address carries the option bit in sector count bit 0
  wire [7:0] scnt_val = (dec_q.cmd == CMD_SETMAX) ? {scnt_q[7:1], opt_q} : scnt_q;
  // Bit 4 stays zero: every device answers as device zero
  wire [7:0] devh_val = DEVH_BASE | (8'(lba_q) << DEVH_LBA);
  // One byte per write cycle, picked by the one-hot state bit; the upper
  // half of the bus stays zero as every command block register here
  // is eight bits wide.
  logic [7:0] wbyte;
  always_comb begin
    unique case (1'b1)
      state_q[1]: wbyte = dec_q.feat;
      state_q[2]: wbyte = scnt_val;
      state_q[3]: wbyte = devh_val;
      state_q[4]: wbyte = dec_q.cmd;
      default: wbyte = 8'h00;
    endcase
  end

  // Strobes decode straight from the state, one cycle per register; the
  // drive enable follows the write strobe, so the bus is released in
  // every cycle in which the device may answer.
  assign tf_wr_o = wr_phase;
  assign tf_data_oe_o = wr_phase;
  assign tf_data_o = {8'h00, wbyte};
  assign tf_rd_o = (state_q == S_RSTAT) | (state_q == S_RERR) | (state_q == S_DRD);
  assign tf_addr_o = (state_q == S_FEAT) ? TF_FEAT :
                     (state_q == S_SCNT) ? TF_SCNT :
                     (state_q == S_DEVH) ? TF_DEVH :
                     (state_q == S_CMD) | (state_q == S_RSTAT) ? TF_CMD :
                     (state_q == S_RERR) ? TF_FEAT : TF_DATA;

  // Capture status then error flags; read data trails the strobe by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= 8'h00;
      error_q <= 8'h00;
    end else begin
      if (state_q == S_RERR) status_q <= tf_data_i[7:0];
      // Only the abort flag is kept; the others carry nothing here
      if (state_q == S_CAP) error_q <= tf_data_i[7:0] & (8'h01 << ER_ABT);
    end
  end

  // Cleared at capture, not at start, so the count of the last transfer
  // stays readable until the next command reaches its capture cycle.
  // Word counter for the sector being read
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q == S_CAP) cnt_q <= 9'h000;
    else if (state_q == S_DCAP) cnt_q <= cnt_q + 9'h001;
  end

  // ----------------------------------------------------------------
  // Interrupts: sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  // An event and a clear in the same cycle keep the bit set, so software
  // that clears early never loses a completion.
  wire w1c = wr & (wb_adr_i == REG_ISTAT) & wb_sel_i[0];
  wire [IRQ_W-1:0] clr = w1c ? wb_dat_i[IRQ_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      istat_q <= IRQ_RST;
      imask_q <= IRQ_RST;
    end else begin
      istat_q <= (istat_q & ~clr) | ev;
      if (wr && wb_adr_i == REG_IMASK && wb_sel_i[0]) imask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end
  assign irq_o = |(istat_q & imask_q);

  // ----------------------------------------------------------------
  // Bus answer: registered ack and data
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero and are still acked, so a stray access
  // never stalls the bus.
  logic [31:0] rmux;
  always_comb begin
    unique case (wb_adr_i)
      REG_STAT: rmux = {7'h00, cnt_q, 14'h0000, (state_q == S_XFER), ~(state_q == S_IDLE)};
      REG_TF: rmux = {16'h0000, error_q, status_q};
      REG_ISTAT: rmux = {29'h0, istat_q};
      REG_IMASK: rmux = {29'h0, imask_q};
      default: rmux = 32'h0; // Unmapped and data outside a transfer
    endcase
  end

  // Other reads and all writes are answered the cycle after they are taken;
  // the data port waits for the device word instead.
  // Data reads are answered one cycle after the taskfile word arrives
  wire ack_d = (req & ~data_rd) | (state_q == S_DCAP);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= ack_d;
      if (state_q == S_DCAP) dat_q <= {16'h0000, tf_data_i};
      else if (rd && !data_rd) dat_q <= rmux;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // All checks run on the system clock and are muted during reset.
  // They watch the taskfile as the device sees it and the register side
  // as software sees it.
  feat_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ok |=> tf_wr_o && tf_addr_o == TF_FEAT && tf_data_o[7:0] == OP_FEAT[$past(wb_dat_i[4:0])]
    ##1 tf_wr_o && tf_addr_o == TF_SCNT ##1 tf_wr_o && tf_addr_o == TF_DEVH
    ##1 tf_wr_o && tf_addr_o == TF_CMD) else $error("feature sequence wrong");
  mon_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CMD && dec_q.feat[7:4] == 4'hd |-> tf_data_o[7:0] == CMD_MON)
    else $error("monitoring code wrong");
  devh_bits_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tf_wr_o && tf_addr_o == TF_DEVH |-> !tf_data_o[4] && tf_data_o[DEVH_LBA] == lba_q)
    else $error("device/head bits wrong");
  option_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_SCNT && dec_q.cmd == CMD_SETMAX |-> tf_data_o[0] == opt_q)
    else $error("option bit wrong");
  one_sector_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_DCAP && last_word |=> state_q == S_IDLE && istat_q[IRQ_DONE])
    else $error("sector length wrong");
  pio_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_q == S_XFER) |-> dec_q.pio_in && !status_q[ST_ERR])
    else $error("data phase on non-pio command");
  abort_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CAP && status_q[ST_ERR] && tf_data_i[ER_ABT] |=> istat_q[IRQ_ABORT]
    && error_q[ER_ABT]) else $error("abort not reported");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  retry_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CMD && dec_q.cmd == CMD_IDENT |-> tf_data_o[0] == 1'b0)
    else $error("retry bit set");

  // Every monitoring subcode sent is one the device lists
  mon_feat_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_FEAT && dec_q.cmd == CMD_MON |->
    tf_data_o[7:0] inside {[8'hd0:8'hd6], [8'hd8:8'hdb]})
    else $error("monitoring subcode not listed");
  // Every configuration subcode sent is a listed on or off code
  cfg_sub_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_FEAT && dec_q.cmd == CMD_CFG |-> tf_data_o[7:0] inside {8'h05, 8'h85,
    8'h66, 8'hcc, 8'h06, 8'h86, 8'h07, 8'h09, 8'h89, 8'h42, 8'hc2, 8'h44, 8'hbb, 8'h55, 8'haa})
    else $error("configuration subcode not listed");
  // The report command carries no subcode
  report_cmd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_FEAT && dec_q.cmd == CMD_IDENT |-> tf_data_o[7:0] == 8'h00)
    else $error("report carries a subcode");
  // Device/head keeps bits 7 and 5 set and the head bits clear
  devh_fixed_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_DEVH |-> tf_data_o[7] && tf_data_o[5] && tf_data_o[3:0] == 4'h0)
    else $error("device/head fixed bits wrong");
  // Mode bits given with the start are the ones kept for the command
  mode_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ok |=> lba_q == $past(wb_dat_i[5]) && opt_q == $past(wb_dat_i[6]))
    else $error("mode bits not latched");
  // Sector count goes out unchanged except for set maximum address
  count_arg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_SCNT && dec_q.cmd != CMD_SETMAX |-> tf_data_o[7:0] == scnt_q)
    else $error("sector count changed");
  // An accepted report with DRQ set enters its data phase next
  report_data_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CAP && dec_q.cmd == CMD_IDENT && status_q[ST_DRQ] && !status_q[ST_ERR]
    |=> state_q == S_XFER) else $error("report without data phase");
  // A command without data finishes at capture with a done event
  nodata_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CAP && !dec_q.pio_in |=> state_q == S_IDLE && istat_q[IRQ_DONE])
    else $error("non-data command not finished");
  // Status is fetched first, then the error flags, right after the interrupt
  status_fetch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT && tf_intrq_i |=> tf_rd_o && tf_addr_o == TF_CMD
    ##1 tf_rd_o && tf_addr_o == TF_FEAT) else $error("status fetch order wrong");
  // Nothing moves on the taskfile while the device is working
  wait_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_WAIT && !tf_intrq_i |=> state_q == S_WAIT && !tf_wr_o && !tf_rd_o)
    else $error("taskfile busy during wait");
  // Only the abort flag survives into the error byte
  abt_only_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_CAP |=> error_q == ($past(tf_data_i[7:0]) & (8'h01 << ER_ABT)))
    else $error("error byte keeps more than abort");
  // The captured word is handed over with the acknowledge that follows
  data_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == S_DCAP |=> wb_ack_o && wb_dat_o == {16'h0000, $past(tf_data_i)})
    else $error("data word not handed over");
  // The word counter never passes one sector while data flows
  word_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    in_xfer |-> cnt_q < 9'(WORDS)) else $error("word count past sector");
  // A bad operation number is flagged and starts nothing
  bad_op_a: assert property (@(posedge clk_i) disable iff (rst_i)
    bad_op |=> istat_q[IRQ_BADOP] && state_q == S_IDLE) else $error("bad op not flagged");
  // A start while busy leaves the command in flight alone
  busy_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_wr && wb_dat_i[7] && state_q != S_IDLE |=> $stable(dec_q) && $stable(scnt_q))
    else $error("start accepted while busy");
  // Events are sticky: a clear in the same cycle loses
  event_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ev != '0 |=> (istat_q & $past(ev)) == $past(ev)) else $error("event lost");
  // A clear with no event removes the bits written as one
  w1c_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    w1c && ev == '0 |=> (istat_q & $past(clr)) == '0) else $error("clear ignored");
  // An enabled event raises the interrupt in the next cycle
  irq_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev & imask_q) != '0 && !(wr && wb_adr_i == REG_IMASK) |=> irq_o)
    else $error("interrupt missing");
  // One state at a time, and never a read and a write together
  state_onehot_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot(state_q) && !(tf_wr_o && tf_rd_o)) else $error("state or strobe clash");

endmodule

//--- verif/dcsd_dev_model.sv
// Behavioural disk device seen through its taskfile registers.
// Assumes one clock shared with the issuer and a registered read path.
`timescale 1ns/10ps
module dcsd_dev_model
  import dcsd_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] tf_addr_i,
  input wire logic [15:0] tf_data_i,
  input wire logic tf_wr_i,
  input wire logic tf_rd_i,
  input wire logic abort_i,
  input wire logic [7:0] delay_i,
  output logic [15:0] tf_data_o,
  output logic tf_intrq_o,
  output logic seen_o,
  output logic [31:0] seen_tf_o
);
  logic [7:0] feat_q, cnt_q, devh_q, st_q, er_q, wait_q; // Taskfile copies and answer delay
  logic [15:0] word_q; // Next sector word
  logic [7:0] cmd_w;
  logic ok_w, pio_w, bad_w;
  assign cmd_w = tf_data_i[7:0];
  // Only listed subcodes are accepted; abort_i lets a test force a rejection
  assign ok_w = (cmd_w == CMD_IDENT) || (cmd_w == CMD_SETMAX)
    || (cmd_w == CMD_MON && feat_q inside {[8'hd0:8'hd6], [8'hd8:8'hdb]})
    || (cmd_w == CMD_CFG && feat_q inside {8'h05, 8'h85, 8'h66, 8'hcc, 8'h06, 8'h86,
    8'h07, 8'h09, 8'h89, 8'h42, 8'hc2, 8'h44, 8'hbb, 8'h55, 8'haa});
  assign bad_w = !ok_w || abort_i;
  // Data-in commands raise DRQ
  assign pio_w = (cmd_w == CMD_IDENT) || (cmd_w == CMD_MON && feat_q inside {8'hd0, 8'hd1, 8'hd5});
  // Register writes, delayed interrupt, registered reads
  always_ff @(posedge clk_i) begin
    seen_o <= 1'b0;
    if (rst_i) begin
      tf_intrq_o <= 1'b0;
      wait_q <= 8'h00;
      tf_data_o <= 16'h0000;
    end else begin
      if (tf_wr_i && tf_addr_i == TF_FEAT) feat_q <= tf_data_i[7:0];
      if (tf_wr_i && tf_addr_i == TF_SCNT) cnt_q <= tf_data_i[7:0];
      if (tf_wr_i && tf_addr_i == TF_DEVH) devh_q <= tf_data_i[7:0];
      if (tf_wr_i && tf_addr_i == TF_CMD) begin
        seen_o <= 1'b1;
        seen_tf_o <= {cmd_w, feat_q, cnt_q, devh_q};
        wait_q <= delay_i | 8'h01;
        word_q <= 16'h5a00;
        st_q <= bad_w ? 8'h51 : (pio_w ? 8'h58 : 8'h50);
        er_q <= bad_w ? 8'h14 : 8'h00;
      end
      if (wait_q != 8'h00) begin
        wait_q <= wait_q - 8'h01;
        tf_intrq_o <= (wait_q == 8'h01);
      end
      if (tf_rd_i && tf_addr_i == TF_CMD) tf_intrq_o <= 1'b0;
      if (tf_rd_i && tf_addr_i == TF_DATA) word_q <= word_q + 16'h0001;
      // Released bus toggles so a stale value is never mistaken for data
      tf_data_o <= ~tf_data_o;
      if (tf_rd_i) begin
        tf_data_o <= (tf_addr_i == TF_DATA) ? word_q
          : {8'h00, (tf_addr_i == TF_FEAT) ? er_q : st_q};
      end
    end
  end
endmodule

//--- verif/test_disk_command_subcode_decoder.sv
// Self-checking bench: issuer driven over Wishbone, device model on taskfile.
// Assumes the register map and operation numbering of the package.
`timescale 1ns/10ps
module test_disk_command_subcode_decoder
  import dcsd_pkg::*;
;
  localparam int NW = 4; // Short sector keeps the run brief
  localparam logic [7:0] FT [N_OPS] = '{8'h00, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hd4, 8'hd5,
    8'hd6, 8'hd8, 8'hd9, 8'hda, 8'hdb, 8'h05, 8'h85, 8'h66, 8'hcc, 8'h06, 8'h86, 8'h07,
    8'h09, 8'h89, 8'h42, 8'hc2, 8'h44, 8'hbb, 8'h55, 8'haa, 8'h00};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, seen_tf;
  logic [3:0] wb_sel_i = 4'hf;
  logic wb_we_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_ack_o, irq_o, tf_data_oe_o, tf_wr_o, tf_rd_o, tf_intrq_i, seen, pio;
  logic abort = 1'b0;
  logic [7:0] delay = 8'h01;
  logic [2:0] tf_addr_o;
  logic [15:0] tf_data_o, tf_data_i;
  logic [63:0] e_rd;
  logic [63:0] q_rd [$]; // Mask and expected read data
  logic [31:0] q_tf [$]; // Expected command block
  int miscompares = 0;
  int n_checks = 0;

  dcsd_host #(.WORDS(NW)) u_dcsd_host (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .irq_o(irq_o),
    .tf_addr_o(tf_addr_o), .tf_data_o(tf_data_o), .tf_data_oe_o(tf_data_oe_o),
    .tf_data_i(tf_data_i), .tf_wr_o(tf_wr_o), .tf_rd_o(tf_rd_o), .tf_intrq_i(tf_intrq_i));
  dcsd_dev_model u_dcsd_dev_model (.clk_i(clk_i), .rst_i(rst_i), .tf_addr_i(tf_addr_o),
    .tf_data_i(tf_data_o), .tf_wr_i(tf_wr_o), .tf_rd_i(tf_rd_o), .abort_i(abort),
    .delay_i(delay), .tf_data_o(tf_data_i), .tf_intrq_o(tf_intrq_i), .seen_o(seen),
    .seen_tf_o(seen_tf));

  initial forever #5 clk_i = ~clk_i;

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Results are compared in issue order as they appear
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      e_rd = q_rd.pop_front();
      check("read", wb_dat_o & e_rd[63:32], e_rd[31:0]);
    end
    if (seen === 1'b1) check("taskfile", seen_tf, q_tf.pop_front());
    // The host drives the bus on its writes and lets go on its reads
    if (tf_wr_o === 1'b1) check("drive enable", {31'h0, tf_data_oe_o}, 32'h1);
    if (tf_rd_o === 1'b1) check("drive release", {31'h0, tf_data_oe_o}, 32'h0);
  end

  // Classic single cycle, held until ack is sampled
  task automatic wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d);
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    q_rd.push_back({m, exp & m});
    wb_cycle(a, 1'b0, 32'h0);
  endtask

  // Start one operation and wait until its error byte has been fetched
  task automatic run(input logic [4:0] op);
    logic lba, opt;
    logic [7:0] cnt, cmd;
    lba = 1'($urandom);
    opt = 1'($urandom);
    cnt = 8'($urandom);
    cmd = (op == 5'd0) ? 8'hec : (op == 5'd27) ? 8'hf9 : (op < 5'd12) ? 8'hb0 : 8'hef;
    q_tf.push_back({cmd, FT[op], ((op == 5'd27) ? {cnt[7:1], opt} : cnt), 1'b1, lba, 6'h20});
    delay <= 8'($urandom_range(1, 150));
    wb_cycle(REG_CTRL, 1'b1, {16'h0, cnt, 1'b1, opt, lba, op});
    do @(posedge clk_i); while (!(tf_rd_o === 1'b1 && tf_addr_o == TF_FEAT));
    repeat (2) @(posedge clk_i);
  endtask

  initial begin
    #200000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(32'h9887));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped hole
    rd(REG_STAT, 32'h0, 32'hffffffff);
    rd(REG_ISTAT, 32'h0, 32'hffffffff);
    rd(REG_IMASK, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    $display("test reset done");
    wb_cycle(REG_IMASK, 1'b1, 32'h7);
    // Every operation, data-in ones drain exactly one sector
    for (int op = 0; op < N_OPS; op++) begin
      run(5'(op));
      pio = (op inside {0, 1, 2, 6});
      if (pio) for (int i = 0; i < NW; i++) rd(REG_DATA, 32'h5a00 + 32'(i), 32'hffff);
      while (irq_o !== 1'b1) @(posedge clk_i);
      rd(REG_ISTAT, 32'h1, 32'h7);
      rd(REG_STAT, pio ? 32'(NW) << 16 : 32'h0, pio ? 32'h01ff0001 : 32'h1);
      if (!pio) rd(REG_TF, 32'h0050, 32'hffff);
      wb_cycle(REG_ISTAT, 1'b1, 32'h7);
    end
    $display("test operations done");
    // Operation numbers past the table
    wb_cycle(REG_CTRL, 1'b1, 32'h9c);
    rd(REG_ISTAT, 32'h4, 32'h7);
    wb_cycle(REG_CTRL, 1'b1, 32'h9f);
    rd(REG_ISTAT, 32'h4, 32'h7);
    wb_cycle(REG_ISTAT, 1'b1, 32'h7);
    $display("test bad op done");
    // Device rejects the command
    abort <= 1'b1;
    run(5'd13);
    while (irq_o !== 1'b1) @(posedge clk_i);
    rd(REG_ISTAT, 32'h2, 32'h2);
    rd(REG_TF, 32'h0451, 32'hffff);
    wb_cycle(REG_ISTAT, 1'b1, 32'h7);
    abort <= 1'b0;
    $display("test abort done");
    // Masked event stays silent until unmasked
    wb_cycle(REG_IMASK, 1'b1, 32'h0);
    run(5'd12);
    repeat (3) @(posedge clk_i);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rd(REG_ISTAT, 32'h1, 32'h1);
    wb_cycle(REG_IMASK, 1'b1, 32'h7);
    @(negedge clk_i);
    check("irq unmasked", {31'h0, irq_o}, 32'h1);
    wb_cycle(REG_ISTAT, 1'b1, 32'h7);
    @(negedge clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    $display("test interrupt done");
    results();
  end
endmodule
